// ---- logic/hpm_regs.svh ----
// constants for the halt power mode controller
// assumes inclusion by bare name from the package and modules
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// =====================================================
// timing, in cpu clock cycles (one cycle = 5 ns at 200 MHz)
`define HPM_CNT_W 13
`define HPM_DLY_SHORT_CYC 13'h0100
`define HPM_DLY_LONG_CYC 13'h1000

// =====================================================
// interrupt mask level values
`define HPM_MASK_W 2
`define HPM_MASK_SLEEP 2'h2
`define HPM_MASK_RESET 2'h3

`endif

// ---- logic/hpm_pkg.sv ----
// types shared by the halt power mode controller files
// assumes hpm_regs.svh is on the include path
`include "hpm_regs.svh"

package hpm_pkg;

   // =====================================================
   // power mode states
   typedef enum logic [2:0] {
      HPM_RUN      = 3'h0,
      HPM_ACT_HALT = 3'h1,
      HPM_HALT     = 3'h2,
      HPM_STAB     = 3'h3,
      HPM_STOP_REM = 3'h4
   } hpm_mode_e;

   // =====================================================
   // controller state
   typedef struct packed {
      hpm_mode_e mode;
      logic exit_irq;
      logic guard;
      logic wake_ext;
      logic wake_tb;
      logic wake_rst;
      logic [`HPM_MASK_W-1:0] mask;
      logic cpu_en;
      logic osc_on;
      logic tb_en;
      logic periph_en;
      logic cond_push;
      logic service;
      logic fetch_rst;
      logic wdg_rst;
   } hpm_ctrl_s;

   // =====================================================
   // delay counter state
   typedef struct packed {
      logic [`HPM_CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } hpm_cnt_s;

endpackage

// ---- logic/hpm_delay_counter.sv ----
// oscillator stabilisation delay counter
// assumes one clock domain and a one-cycle start pulse
`timescale 1ns/1ps
`include "hpm_regs.svh"

module hpm_delay_counter import hpm_pkg::*; #(
   parameter logic [`HPM_CNT_W-1:0] DLY_SHORT = `HPM_DLY_SHORT_CYC,
   parameter logic [`HPM_CNT_W-1:0] DLY_LONG = `HPM_DLY_LONG_CYC
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_long,
   output logic o_busy,
   output logic o_done
);

   hpm_cnt_s c_reg;
   hpm_cnt_s c_next;

   // =====================================================
   // count down, done pulse after the last cycle
   always_comb begin
      c_next = c_reg;
      c_next.done = 1'b0;
      if (i_start) begin
         c_next.cnt = i_long ? DLY_LONG - 13'h0001 : DLY_SHORT - 13'h0001;
         c_next.busy = 1'b1;
      end else if (c_reg.busy) begin
         if (c_reg.cnt == '0) begin
            c_next.busy = 1'b0;
            c_next.done = 1'b1;
         end else begin
            c_next.cnt = c_reg.cnt - 13'h0001;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   assign o_busy = c_reg.busy;
   assign o_done = c_reg.done;

endmodule

// ---- logic/hpm_halt_ctrl.sv ----
// halt and timebase-sleep power mode controller
// assumes cpu, oscillator and interrupt logic share i_clock; inputs synchronous
`timescale 1ns/1ps
`include "hpm_regs.svh"

// Contract
// - stop instruction: enable picks sleep kind
// - timebase sleep woken by timebase or reset
// - timebase wake: no delay, service now
// - reset exit from timebase sleep delayed
// - entry forces mask 10, pending wakes
// - timebase sleep: oscillator and timebase only
// - enable set: no watchdog reset entering
// - enable cleared early: clock stop remainder
// - clock stop ends on reset, wake irq
// - clock stop exit: oscillator on, wait
// - clock stop: oscillator and all halted
// - option bit decides watchdog reset on stop
// - service pushes condition code, sets mask
module hpm_halt_ctrl import hpm_pkg::*; #(
   parameter logic [`HPM_CNT_W-1:0] DLY_SHORT = `HPM_DLY_SHORT_CYC,
   parameter logic [`HPM_CNT_W-1:0] DLY_LONG = `HPM_DLY_LONG_CYC
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_halt_exec,
   input wire logic i_osc_irq_enable,
   input wire logic i_long_delay,
   input wire logic i_timebase_irq,
   input wire logic i_ext_wake_irq,
   input wire logic i_irq_pending,
   input wire logic i_reset_req,
   input wire logic i_watchdog_active,
   input wire logic i_watchdog_sleep_option,
   input wire logic [`HPM_MASK_W-1:0] i_isr_level,
   input wire logic i_cond_pop,
   input wire logic [`HPM_MASK_W-1:0] i_pop_level,
   input wire logic i_mask_wr,
   input wire logic [`HPM_MASK_W-1:0] i_mask_wdata,
   output logic [2:0] o_mode,
   output logic o_cpu_clk_en,
   output logic o_osc_on,
   output logic o_timebase_clk_en,
   output logic o_periph_clk_en,
   output logic [`HPM_MASK_W-1:0] o_mask_level,
   output logic o_cond_push,
   output logic o_service_irq,
   output logic o_fetch_reset_vec,
   output logic o_watchdog_reset
);

   hpm_ctrl_s st_reg;
   hpm_ctrl_s st_next;
   logic cnt_start;
   logic cnt_busy;
   logic cnt_done;

   // =====================================================
   // stabilisation and guard delay
   hpm_delay_counter #(
      .DLY_SHORT(DLY_SHORT),
      .DLY_LONG(DLY_LONG)
   ) u_delay (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start(cnt_start),
      .i_long(i_long_delay),
      .o_busy(cnt_busy),
      .o_done(cnt_done)
   );

   // =====================================================
   // next state
   always_comb begin
      st_next = st_reg;
      cnt_start = 1'b0;
      st_next.cond_push = 1'b0;
      st_next.service = 1'b0;
      st_next.fetch_rst = 1'b0;
      st_next.wdg_rst = 1'b0;
      st_next.wake_ext = st_reg.wake_ext | i_ext_wake_irq;
      st_next.wake_tb = st_reg.wake_tb | i_timebase_irq;
      st_next.wake_rst = st_reg.wake_rst | i_reset_req;
      if (i_cond_pop) begin
         st_next.mask = i_pop_level;
      end else if (i_mask_wr) begin
         st_next.mask = i_mask_wdata;
      end
      unique case (st_reg.mode)
         HPM_RUN: begin
            st_next.wake_ext = 1'b0;
            st_next.wake_tb = 1'b0;
            st_next.wake_rst = 1'b0;
            if (cnt_done) begin
               st_next.guard = 1'b0;
            end
            if (i_reset_req) begin
               st_next.fetch_rst = 1'b1;
               st_next.guard = 1'b0;
            end else if (i_halt_exec) begin
               st_next.mask = `HPM_MASK_SLEEP;
               if (i_irq_pending) begin
                  st_next.service = 1'b1;
                  st_next.cond_push = 1'b1;
                  st_next.mask = i_isr_level;
               end else if (i_osc_irq_enable) begin
                  st_next.mode = HPM_ACT_HALT;
                  st_next.guard = 1'b0;
               end else if (i_watchdog_active && !i_watchdog_sleep_option) begin
                  st_next.wdg_rst = 1'b1;
               end else begin
                  st_next.mode = HPM_HALT;
                  st_next.guard = 1'b0;
               end
            end else if (st_reg.guard && !i_osc_irq_enable && cnt_busy) begin
               st_next.mode = HPM_STOP_REM;
            end
         end
         HPM_ACT_HALT: begin
            if (i_reset_req || st_reg.wake_rst) begin
               st_next.mode = HPM_STAB;
               st_next.exit_irq = 1'b0;
               cnt_start = 1'b1;
            end else if (i_timebase_irq || st_reg.wake_tb) begin
               st_next.mode = HPM_RUN;
               st_next.service = 1'b1;
               st_next.cond_push = 1'b1;
               st_next.mask = i_isr_level;
               st_next.guard = 1'b1;
               cnt_start = 1'b1;
            end
         end
         HPM_HALT: begin
            if (i_reset_req || st_reg.wake_rst) begin
               st_next.mode = HPM_STAB;
               st_next.exit_irq = 1'b0;
               cnt_start = 1'b1;
            end else if (i_ext_wake_irq || st_reg.wake_ext) begin
               st_next.mode = HPM_STAB;
               st_next.exit_irq = 1'b1;
               cnt_start = 1'b1;
            end
         end
         HPM_STAB: begin
            if (cnt_done) begin
               st_next.mode = HPM_RUN;
               if (st_reg.exit_irq) begin
                  st_next.service = 1'b1;
                  st_next.cond_push = 1'b1;
                  st_next.mask = i_isr_level;
               end else begin
                  st_next.fetch_rst = 1'b1;
               end
            end
         end
         HPM_STOP_REM: begin
            if (i_reset_req || st_reg.wake_rst) begin
               st_next.mode = HPM_STAB;
               st_next.exit_irq = 1'b0;
               st_next.guard = 1'b0;
               cnt_start = 1'b1;
            end else if (cnt_done) begin
               st_next.mode = HPM_RUN;
               st_next.guard = 1'b0;
            end
         end
         default: begin
            st_next.mode = HPM_RUN;
         end
      endcase
      st_next.cpu_en = (st_next.mode == HPM_RUN);
      st_next.periph_en = (st_next.mode == HPM_RUN);
      st_next.osc_on = (st_next.mode != HPM_HALT) && (st_next.mode != HPM_STOP_REM);
      st_next.tb_en = (st_next.mode == HPM_RUN) || (st_next.mode == HPM_ACT_HALT);
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_reg.mode <= HPM_RUN;
         st_reg.exit_irq <= 1'b0;
         st_reg.guard <= 1'b0;
         st_reg.wake_ext <= 1'b0;
         st_reg.wake_tb <= 1'b0;
         st_reg.wake_rst <= 1'b0;
         st_reg.mask <= `HPM_MASK_RESET;
         st_reg.cpu_en <= 1'b1;
         st_reg.osc_on <= 1'b1;
         st_reg.tb_en <= 1'b1;
         st_reg.periph_en <= 1'b1;
         st_reg.cond_push <= 1'b0;
         st_reg.service <= 1'b0;
         st_reg.fetch_rst <= 1'b0;
         st_reg.wdg_rst <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // =====================================================
   // outputs
   assign o_mode = st_reg.mode;
   assign o_cpu_clk_en = st_reg.cpu_en;
   assign o_osc_on = st_reg.osc_on;
   assign o_timebase_clk_en = st_reg.tb_en;
   assign o_periph_clk_en = st_reg.periph_en;
   assign o_mask_level = st_reg.mask;
   assign o_cond_push = st_reg.cond_push;
   assign o_service_irq = st_reg.service;
   assign o_fetch_reset_vec = st_reg.fetch_rst;
   assign o_watchdog_reset = st_reg.wdg_rst;

   // =====================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   logic run_entry;
   assign run_entry = (st_reg.mode == HPM_RUN) && i_halt_exec && !i_reset_req && !i_irq_pending;

   sequence s_halt_wake;
      st_reg.mode == HPM_HALT && !i_reset_req && !st_reg.wake_rst && i_ext_wake_irq;
   endsequence

   sequence s_stab_hold;
      st_reg.mode == HPM_STAB && o_osc_on && !o_cpu_clk_en ##1 st_reg.mode == HPM_STAB [*8];
   endsequence

   a_entry_select: assert property (
      run_entry |=> ($past(i_osc_irq_enable) ? st_reg.mode == HPM_ACT_HALT
      : (st_reg.mode == HPM_HALT || o_watchdog_reset)))
      else $error("wrong sleep kind on stop instruction");

   a_tb_only_wake: assert property (
      st_reg.mode == HPM_ACT_HALT && !i_timebase_irq && !i_reset_req && !st_reg.wake_tb
      && !st_reg.wake_rst |=> st_reg.mode == HPM_ACT_HALT)
      else $error("timebase sleep left without timebase or reset");

   a_tb_no_delay: assert property (
      st_reg.mode == HPM_ACT_HALT && i_timebase_irq && !i_reset_req && !st_reg.wake_rst
      |=> o_service_irq && o_cpu_clk_en && st_reg.mode == HPM_RUN)
      else $error("timebase wake not serviced at once");

   a_rst_delayed: assert property (
      st_reg.mode == HPM_ACT_HALT && i_reset_req |=> !o_fetch_reset_vec [*8])
      else $error("reset vector fetched without delay");

   a_mask_forced: assert property (
      run_entry && !i_cond_pop |=> o_mask_level == `HPM_MASK_SLEEP)
      else $error("mask not forced on sleep entry");

   a_act_clocks: assert property (
      st_reg.mode == HPM_ACT_HALT |-> o_osc_on && o_timebase_clk_en && !o_cpu_clk_en && !o_periph_clk_en)
      else $error("wrong clocks in timebase sleep");

   a_wdg_enable: assert property (
      st_reg.mode == HPM_RUN && i_halt_exec && i_osc_irq_enable |=> !o_watchdog_reset)
      else $error("watchdog reset with timebase sleep");

   a_guard_stop: assert property (
      st_reg.mode == HPM_RUN && st_reg.guard && cnt_busy && !i_osc_irq_enable && !i_halt_exec
      && !i_reset_req |=> st_reg.mode == HPM_STOP_REM && !o_osc_on)
      else $error("early enable clear did not stop clock");

   a_stop_wake_only: assert property (
      st_reg.mode == HPM_HALT && !i_ext_wake_irq && !i_reset_req && !st_reg.wake_ext
      && !st_reg.wake_rst |=> st_reg.mode == HPM_HALT)
      else $error("clock stop left without wake interrupt or reset");

   a_halt_stab: assert property (
      s_halt_wake |=> s_stab_hold)
      else $error("clock stop exit skipped stabilisation");

   a_halt_off: assert property (
      st_reg.mode == HPM_HALT |-> !o_osc_on && !o_cpu_clk_en && !o_periph_clk_en && !o_timebase_clk_en)
      else $error("clocks running in clock stop");

   a_wdg_option: assert property (
      run_entry && !i_osc_irq_enable && i_watchdog_active && !i_watchdog_sleep_option
      |=> o_watchdog_reset && st_reg.mode == HPM_RUN)
      else $error("watchdog option not honoured");

   a_service_push: assert property (
      st_reg.mode == HPM_STAB && cnt_done && st_reg.exit_irq
      |=> o_service_irq && o_cond_push && o_mask_level == $past(i_isr_level))
      else $error("service without push or priority");

endmodule

// ---- tb/hpm_core_model.sv ----
// cpu stack model: pops the condition code a few cycles after each push
// assumes the bench clock; outputs change on the falling edge
`timescale 1ns/1ps
`include "hpm_regs.svh"

module hpm_core_model import hpm_pkg::*; #(
   parameter int POP_GAP = 3
) (
   input wire logic i_clock,
   input wire logic i_cond_push,
   input wire logic [`HPM_MASK_W-1:0] i_mask_level,
   output logic o_cond_pop,
   output logic [`HPM_MASK_W-1:0] o_pop_level
);
   logic [`HPM_MASK_W-1:0] prev_reg;
   logic [`HPM_MASK_W-1:0] saved_reg;
   int gap;

   initial begin
      o_cond_pop = 1'b0;
      o_pop_level = 2'h0;
      prev_reg = 2'h3;
      saved_reg = 2'h3;
      gap = 0;
   end

   // =====================================================
   // return restores pushed level
   always @(negedge i_clock) begin
      o_cond_pop = 1'b0;
      if (i_cond_push === 1'b1) begin
         saved_reg = prev_reg;
         gap = POP_GAP;
      end else if (gap > 0) begin
         gap--;
         o_cond_pop = (gap == 0);
      end
      // level is only valid with the pop strobe
      o_pop_level = o_cond_pop ? saved_reg : ~saved_reg;
      prev_reg = i_mask_level;
   end
endmodule

// ---- tb/halt_power_mode_control_tb.sv ----
// bench for the halt power mode controller
// assumes hpm_pkg compiled first and the core model beside it
`timescale 1ns/1ps

module halt_power_mode_control_tb import hpm_pkg::*; ;
   localparam int NS = 10;
   localparam int NL = 16;
   logic i_clock, i_rst, i_halt_exec, i_osc_irq_enable, i_long_delay, i_timebase_irq;
   logic i_ext_wake_irq, i_irq_pending, i_reset_req, i_watchdog_active, i_watchdog_sleep_option;
   logic i_cond_pop, i_mask_wr;
   logic [1:0] i_isr_level, i_pop_level, i_mask_wdata, o_mask_level;
   logic [2:0] o_mode;
   logic o_cpu_clk_en, o_osc_on, o_timebase_clk_en, o_periph_clk_en;
   logic o_cond_push, o_service_irq, o_fetch_reset_vec, o_watchdog_reset;
   int err_count = 0;
   int checks = 0;
   int n;

   hpm_halt_ctrl #(.DLY_SHORT(13'h000A), .DLY_LONG(13'h0010)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_halt_exec(i_halt_exec), .i_osc_irq_enable(i_osc_irq_enable), .i_long_delay(i_long_delay),
      .i_timebase_irq(i_timebase_irq), .i_ext_wake_irq(i_ext_wake_irq), .i_irq_pending(i_irq_pending),
      .i_reset_req(i_reset_req), .i_watchdog_active(i_watchdog_active),
      .i_watchdog_sleep_option(i_watchdog_sleep_option), .i_isr_level(i_isr_level),
      .i_cond_pop(i_cond_pop), .i_pop_level(i_pop_level), .i_mask_wr(i_mask_wr),
      .i_mask_wdata(i_mask_wdata), .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en), .o_osc_on(o_osc_on),
      .o_timebase_clk_en(o_timebase_clk_en), .o_periph_clk_en(o_periph_clk_en),
      .o_mask_level(o_mask_level), .o_cond_push(o_cond_push), .o_service_irq(o_service_irq),
      .o_fetch_reset_vec(o_fetch_reset_vec), .o_watchdog_reset(o_watchdog_reset));

   hpm_core_model i_core (.i_clock(i_clock), .i_cond_push(o_cond_push), .i_mask_level(o_mask_level),
      .o_cond_pop(i_cond_pop), .o_pop_level(i_pop_level));

   // =====================================================
   // helpers
   function automatic logic [7:0] md();
      return {5'h00, o_mode};
   endfunction
   function automatic logic [7:0] en4();
      return {4'h0, o_cpu_clk_en, o_osc_on, o_timebase_clk_en, o_periph_clk_en};
   endfunction
   function automatic logic [7:0] pl();
      return {4'h0, o_cond_push, o_service_irq, o_fetch_reset_vec, o_watchdog_reset};
   endfunction
   function automatic logic [7:0] msk();
      return {6'h00, o_mask_level};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge i_clock);
   endtask

   task automatic halt(input logic en);
      i_osc_irq_enable = en;
      i_halt_exec = 1'b1;
      cyc(1);
      i_halt_exec = 1'b0;
   endtask

   // sel 0 service, 1 reset fetch, 2 back in run
   task automatic wait_out(input int sel, output int c);
      logic hit;
      c = 0;
      hit = 1'b0;
      while (c < 40 && hit !== 1'b1) begin
         cyc(1);
         c++;
         hit = (sel == 0) ? o_service_irq : ((sel == 1) ? o_fetch_reset_vec : (o_mode === 3'h0));
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // =====================================================
   // scenarios
   task automatic t_reset();
      chk(md(), 8'h00);
      chk(en4(), 8'h0F);
      chk(msk(), 8'h03);
      chk(pl(), 8'h00);
      $display("test reset done");
   endtask

   task automatic t_tb_sleep();
      i_mask_wr = 1'b1;
      i_mask_wdata = 2'h0;
      cyc(1);
      i_mask_wr = 1'b0;
      chk(msk(), 8'h00);
      i_watchdog_active = 1'b1;
      i_watchdog_sleep_option = 1'b0;
      halt(1'b1);
      chk(md(), 8'h01);
      chk(en4(), 8'h06);
      chk(msk(), 8'h02);
      chk(pl(), 8'h00);
      i_ext_wake_irq = 1'b1;
      cyc(3);
      chk(md(), 8'h01);
      i_ext_wake_irq = 1'b0;
      i_timebase_irq = 1'b1;
      cyc(1);
      i_timebase_irq = 1'b0;
      chk(pl(), 8'h0C);
      chk(md(), 8'h00);
      chk(msk(), 8'h01);
      cyc(NS + 4);
      chk(md(), 8'h00);
      chk(msk(), 8'h02);
      i_watchdog_active = 1'b0;
      $display("test timebase sleep done");
   endtask

   task automatic t_guard();
      halt(1'b1);
      i_timebase_irq = 1'b1;
      cyc(1);
      i_timebase_irq = 1'b0;
      chk(pl(), 8'h0C);
      i_osc_irq_enable = 1'b0;
      cyc(1);
      chk(md(), 8'h04);
      chk(en4(), 8'h00);
      wait_out(2, n);
      chk(8'(n), 8'(NS));
      chk(pl(), 8'h00);
      cyc(6);
      $display("test guard done");
   endtask

   task automatic t_stop();
      for (int k = 0; k < 2; k++) begin
         i_long_delay = k[0];
         i_watchdog_active = 1'b1;
         i_watchdog_sleep_option = 1'b1;
         i_irq_pending = 1'b0;
         halt(1'b0);
         chk(md(), 8'h02);
         chk(en4(), 8'h00);
         chk(msk(), 8'h02);
         i_timebase_irq = 1'b1;
         cyc(2);
         i_timebase_irq = 1'b0;
         chk(md(), 8'h02);
         i_ext_wake_irq = 1'b1;
         cyc(1);
         i_ext_wake_irq = 1'b0;
         chk(md(), 8'h03);
         chk(en4(), 8'h04);
         wait_out(0, n);
         chk(8'(n), 8'((k == 1 ? NL : NS) + 1));
         chk(pl(), 8'h0C);
         chk(md(), 8'h00);
         cyc(6);
      end
      i_long_delay = 1'b0;
      i_watchdog_active = 1'b0;
      $display("test clock stop done");
   endtask

   task automatic t_reset_exit();
      for (int k = 0; k < 2; k++) begin
         halt(k[0]);
         i_reset_req = 1'b1;
         i_timebase_irq = 1'b1;
         cyc(1);
         i_reset_req = 1'b0;
         i_timebase_irq = 1'b0;
         chk(md(), 8'h03);
         wait_out(1, n);
         chk(8'(n), 8'(NS + 1));
         chk(pl(), 8'h02);
         cyc(6);
      end
      $display("test reset exit done");
   endtask

   task automatic t_wdg();
      i_watchdog_active = 1'b1;
      i_watchdog_sleep_option = 1'b0;
      halt(1'b0);
      chk(md(), 8'h00);
      chk(pl(), 8'h01);
      cyc(1);
      chk(pl(), 8'h00);
      i_watchdog_active = 1'b0;
      $display("test watchdog done");
   endtask

   task automatic t_pending();
      for (int k = 0; k < 2; k++) begin
         i_isr_level = 2'h3 - 2'(k);
         i_irq_pending = 1'b1;
         halt(k[0]);
         i_irq_pending = 1'b0;
         chk(md(), 8'h00);
         chk(pl(), 8'h0C);
         chk(msk(), {6'h00, i_isr_level});
         cyc(6);
      end
      $display("test pending done");
   endtask

   task automatic t_mid_reset();
      halt(1'b0);
      chk(md(), 8'h02);
      i_rst = 1'b1;
      cyc(2);
      i_rst = 1'b0;
      chk(md(), 8'h00);
      chk(en4(), 8'h0F);
      chk(msk(), 8'h03);
      chk(pl(), 8'h00);
      i_reset_req = 1'b1;
      cyc(1);
      i_reset_req = 1'b0;
      chk(pl(), 8'h02);
      chk(md(), 8'h00);
      cyc(2);
      $display("test mid reset done");
   endtask

   // =====================================================
   // clock, watchdog and main sequence
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   initial begin
      #50000;
      err_count++;
      wrap_up();
   end

   initial begin
      {i_halt_exec, i_osc_irq_enable, i_long_delay, i_timebase_irq, i_ext_wake_irq} = 5'h00;
      {i_irq_pending, i_reset_req, i_watchdog_active, i_watchdog_sleep_option, i_mask_wr} = 5'h00;
      i_isr_level = 2'h1;
      i_mask_wdata = 2'h0;
      i_rst = 1'b1;
      cyc(4);
      i_rst = 1'b0;
      t_reset();
      t_tb_sleep();
      t_guard();
      t_stop();
      t_reset_exit();
      t_wdg();
      t_pending();
      t_mid_reset();
      wrap_up();
   end
endmodule
